// ==== design/dmasb_defines.vh ====
/*
  constants for the dma subbank register access block: the direct
  register locations, the subaddress map and reset values.
  assumes a 16-bit data-space register bus with the data-space
  address in 16 bits.
*/
// Contract
// - priority/enable register directly mapped
// - other registers reached via subbank pointer
// - data-port access targets pointer-selected register
// - incrementing port adds one to pointer
// - plain port leaves pointer unchanged
// - 00h-1Dh: five registers per channel
// - 1Eh/1Fh shared program page registers
// - 20h/21h element step registers
// - 22h/23h frame step registers
// - 24h-27h channel 0 reload registers
// - 28h/29h extended pages, unsupported
// - 2Ah-3Dh reload registers channels 1-5
// - pointer sits just below data ports
// - incrementing port lower, plain port upper
`ifndef DMASB_DEFINES_VH
`define DMASB_DEFINES_VH

// ----------------------------------------------------------------
// direct register locations
// ----------------------------------------------------------------
`define DMASB_ADDR_PRIORITY 16'h0054
`define DMASB_ADDR_POINTER 16'h0055
`define DMASB_ADDR_INC_PORT 16'h0056
`define DMASB_ADDR_PLAIN_PORT 16'h0057

// ----------------------------------------------------------------
// subaddress map
// ----------------------------------------------------------------
`define DMASB_SUB_CHAN_LAST 8'h1d
`define DMASB_SUB_SRC_PAGE 8'h1e
`define DMASB_SUB_DST_PAGE 8'h1f
`define DMASB_SUB_ELEM_STEP0 8'h20
`define DMASB_SUB_ELEM_STEP1 8'h21
`define DMASB_SUB_FRAME_STEP0 8'h22
`define DMASB_SUB_FRAME_STEP1 8'h23
`define DMASB_SUB_RELOAD0_FIRST 8'h24
`define DMASB_SUB_RELOAD0_LAST 8'h27
`define DMASB_SUB_EXT_SRC 8'h28
`define DMASB_SUB_EXT_DST 8'h29
`define DMASB_SUB_RELOAD1_FIRST 8'h2a
`define DMASB_SUB_LAST 8'h3d

// ----------------------------------------------------------------
// subaddress of each register
// ----------------------------------------------------------------
`define DMASB_SUB_CH0_SRC 8'h00
`define DMASB_SUB_CH0_DST 8'h01
`define DMASB_SUB_CH0_COUNT 8'h02
`define DMASB_SUB_CH0_SYNC 8'h03
`define DMASB_SUB_CH0_MODE 8'h04
`define DMASB_SUB_CH1_SRC 8'h05
`define DMASB_SUB_CH1_DST 8'h06
`define DMASB_SUB_CH1_COUNT 8'h07
`define DMASB_SUB_CH1_SYNC 8'h08
`define DMASB_SUB_CH1_MODE 8'h09
`define DMASB_SUB_CH2_SRC 8'h0a
`define DMASB_SUB_CH2_DST 8'h0b
`define DMASB_SUB_CH2_COUNT 8'h0c
`define DMASB_SUB_CH2_SYNC 8'h0d
`define DMASB_SUB_CH2_MODE 8'h0e
`define DMASB_SUB_CH3_SRC 8'h0f
`define DMASB_SUB_CH3_DST 8'h10
`define DMASB_SUB_CH3_COUNT 8'h11
`define DMASB_SUB_CH3_SYNC 8'h12
`define DMASB_SUB_CH3_MODE 8'h13
`define DMASB_SUB_CH4_SRC 8'h14
`define DMASB_SUB_CH4_DST 8'h15
`define DMASB_SUB_CH4_COUNT 8'h16
`define DMASB_SUB_CH4_SYNC 8'h17
`define DMASB_SUB_CH4_MODE 8'h18
`define DMASB_SUB_CH5_SRC 8'h19
`define DMASB_SUB_CH5_DST 8'h1a
`define DMASB_SUB_CH5_COUNT 8'h1b
`define DMASB_SUB_CH5_SYNC 8'h1c
`define DMASB_SUB_CH5_MODE 8'h1d
`define DMASB_SUB_RELOAD0_SRC 8'h24
`define DMASB_SUB_RELOAD0_DST 8'h25
`define DMASB_SUB_RELOAD0_COUNT 8'h26
`define DMASB_SUB_RELOAD0_FRAME 8'h27
`define DMASB_SUB_RELOAD1_SRC 8'h2a
`define DMASB_SUB_RELOAD1_DST 8'h2b
`define DMASB_SUB_RELOAD1_COUNT 8'h2c
`define DMASB_SUB_RELOAD1_FRAME 8'h2d
`define DMASB_SUB_RELOAD2_SRC 8'h2e
`define DMASB_SUB_RELOAD2_DST 8'h2f
`define DMASB_SUB_RELOAD2_COUNT 8'h30
`define DMASB_SUB_RELOAD2_FRAME 8'h31
`define DMASB_SUB_RELOAD3_SRC 8'h32
`define DMASB_SUB_RELOAD3_DST 8'h33
`define DMASB_SUB_RELOAD3_COUNT 8'h34
`define DMASB_SUB_RELOAD3_FRAME 8'h35
`define DMASB_SUB_RELOAD4_SRC 8'h36
`define DMASB_SUB_RELOAD4_DST 8'h37
`define DMASB_SUB_RELOAD4_COUNT 8'h38
`define DMASB_SUB_RELOAD4_FRAME 8'h39
`define DMASB_SUB_RELOAD5_SRC 8'h3a
`define DMASB_SUB_RELOAD5_DST 8'h3b
`define DMASB_SUB_RELOAD5_COUNT 8'h3c
`define DMASB_SUB_RELOAD5_FRAME 8'h3d
// storage slots: 0..27h hold themselves, 2ah..3dh fold down by two
`define DMASB_SLOT_COUNT 60
`define DMASB_RELOAD_FOLD 6'h02

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DMASB_RST_REG 16'h0000
`define DMASB_RST_POINTER 16'h0000

`endif

// ==== design/dmasb_regs.v ====
/*
  dma subbank register access: the directly mapped priority/enable
  register, the subbank pointer, and the two data ports that reach the
  subbank storage through it. the incrementing port steps the pointer
  after every access, read or write; the plain port leaves it alone.
  storage covers the channel sets, shared pages, step registers and
  reload registers; the two extended page subaddresses and everything
  past the last reload register are unlisted and read as zero.
  assumes a single-cycle register bus from the core: one access per
  cycle with a strobe, address and write flag; the bus is synchronous
  to mclk. read data is returned from a flop in the cycle after the
  strobe and is zero in every other cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmasb_defines.vh"

module dmasb_regs (
  input wire mclk,
  input wire rst_b,
  input wire busSel,
  input wire busWrite,
  input wire [15:0] busAddr,
  input wire [15:0] busWdata,
  output reg [15:0] busRdata,
  output wire busHit,
  output wire [15:0] priorityEnable,
  output wire [15:0] subbankPointer
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // direct register and pointer
  reg [15:0] prio_ff;
  reg [15:0] ptr_ff;
  // subbank slots, indexed by slotOf below; plain flops, since the
  // block is small enough that a memory macro would not pay off
  reg [15:0] slot_ff [0:`DMASB_SLOT_COUNT-1];
  // next-state values of the read flop and the pointer
  reg [15:0] nxt_busRdata;
  reg [15:0] nxt_ptr;
  // reset loop index
  integer i;

  // ----------------------------------------------------------------
  // subaddress map
  // ----------------------------------------------------------------
  // map a subaddress to a storage slot; bit 6 flags a real register.
  // every register is listed by name, so a map change touches one
  // line here and one in the header, never any arithmetic.
  // slots 00h..27h equal the subaddress; the reload sets of channels
  // 1 to 5 sit two slots lower, closing the gap of the extended pages,
  // which keeps the storage free of flops that nobody can use
  function [6:0] slotOf;
    input [15:0] sub;
    begin
      // anything not listed reads zero and takes no write
      slotOf = 7'h00;
      if (sub[15:8] == 8'h00) begin
        case (sub[7:0])
          // channel 0 working set
          `DMASB_SUB_CH0_SRC: begin
            slotOf = 7'h40;
          end
          `DMASB_SUB_CH0_DST: begin
            slotOf = 7'h41;
          end
          `DMASB_SUB_CH0_COUNT: begin
            slotOf = 7'h42;
          end
          `DMASB_SUB_CH0_SYNC: begin
            slotOf = 7'h43;
          end
          `DMASB_SUB_CH0_MODE: begin
            slotOf = 7'h44;
          end
          // channel 1 working set
          `DMASB_SUB_CH1_SRC: begin
            slotOf = 7'h45;
          end
          `DMASB_SUB_CH1_DST: begin
            slotOf = 7'h46;
          end
          `DMASB_SUB_CH1_COUNT: begin
            slotOf = 7'h47;
          end
          `DMASB_SUB_CH1_SYNC: begin
            slotOf = 7'h48;
          end
          `DMASB_SUB_CH1_MODE: begin
            slotOf = 7'h49;
          end
          // channel 2 working set
          `DMASB_SUB_CH2_SRC: begin
            slotOf = 7'h4a;
          end
          `DMASB_SUB_CH2_DST: begin
            slotOf = 7'h4b;
          end
          `DMASB_SUB_CH2_COUNT: begin
            slotOf = 7'h4c;
          end
          `DMASB_SUB_CH2_SYNC: begin
            slotOf = 7'h4d;
          end
          `DMASB_SUB_CH2_MODE: begin
            slotOf = 7'h4e;
          end
          // channel 3 working set
          `DMASB_SUB_CH3_SRC: begin
            slotOf = 7'h4f;
          end
          `DMASB_SUB_CH3_DST: begin
            slotOf = 7'h50;
          end
          `DMASB_SUB_CH3_COUNT: begin
            slotOf = 7'h51;
          end
          `DMASB_SUB_CH3_SYNC: begin
            slotOf = 7'h52;
          end
          `DMASB_SUB_CH3_MODE: begin
            slotOf = 7'h53;
          end
          // channel 4 working set
          `DMASB_SUB_CH4_SRC: begin
            slotOf = 7'h54;
          end
          `DMASB_SUB_CH4_DST: begin
            slotOf = 7'h55;
          end
          `DMASB_SUB_CH4_COUNT: begin
            slotOf = 7'h56;
          end
          `DMASB_SUB_CH4_SYNC: begin
            slotOf = 7'h57;
          end
          `DMASB_SUB_CH4_MODE: begin
            slotOf = 7'h58;
          end
          // channel 5 working set
          `DMASB_SUB_CH5_SRC: begin
            slotOf = 7'h59;
          end
          `DMASB_SUB_CH5_DST: begin
            slotOf = 7'h5a;
          end
          `DMASB_SUB_CH5_COUNT: begin
            slotOf = 7'h5b;
          end
          `DMASB_SUB_CH5_SYNC: begin
            slotOf = 7'h5c;
          end
          `DMASB_SUB_CH5_MODE: begin
            slotOf = 7'h5d;
          end
          // program pages shared by all channels
          `DMASB_SUB_SRC_PAGE: begin
            slotOf = 7'h5e;
          end
          `DMASB_SUB_DST_PAGE: begin
            slotOf = 7'h5f;
          end
          // element steps
          `DMASB_SUB_ELEM_STEP0: begin
            slotOf = 7'h60;
          end
          `DMASB_SUB_ELEM_STEP1: begin
            slotOf = 7'h61;
          end
          // frame steps
          `DMASB_SUB_FRAME_STEP0: begin
            slotOf = 7'h62;
          end
          `DMASB_SUB_FRAME_STEP1: begin
            slotOf = 7'h63;
          end
          // channel 0 reload set
          `DMASB_SUB_RELOAD0_SRC: begin
            slotOf = 7'h64;
          end
          `DMASB_SUB_RELOAD0_DST: begin
            slotOf = 7'h65;
          end
          `DMASB_SUB_RELOAD0_COUNT: begin
            slotOf = 7'h66;
          end
          `DMASB_SUB_RELOAD0_FRAME: begin
            slotOf = 7'h67;
          end
          // extended pages are not supported: no storage
          `DMASB_SUB_EXT_SRC: begin
            slotOf = 7'h00;
          end
          `DMASB_SUB_EXT_DST: begin
            slotOf = 7'h00;
          end
          // channel 1 reload set
          `DMASB_SUB_RELOAD1_SRC: begin
            slotOf = 7'h68;
          end
          `DMASB_SUB_RELOAD1_DST: begin
            slotOf = 7'h69;
          end
          `DMASB_SUB_RELOAD1_COUNT: begin
            slotOf = 7'h6a;
          end
          `DMASB_SUB_RELOAD1_FRAME: begin
            slotOf = 7'h6b;
          end
          // channel 2 reload set
          `DMASB_SUB_RELOAD2_SRC: begin
            slotOf = 7'h6c;
          end
          `DMASB_SUB_RELOAD2_DST: begin
            slotOf = 7'h6d;
          end
          `DMASB_SUB_RELOAD2_COUNT: begin
            slotOf = 7'h6e;
          end
          `DMASB_SUB_RELOAD2_FRAME: begin
            slotOf = 7'h6f;
          end
          // channel 3 reload set
          `DMASB_SUB_RELOAD3_SRC: begin
            slotOf = 7'h70;
          end
          `DMASB_SUB_RELOAD3_DST: begin
            slotOf = 7'h71;
          end
          `DMASB_SUB_RELOAD3_COUNT: begin
            slotOf = 7'h72;
          end
          `DMASB_SUB_RELOAD3_FRAME: begin
            slotOf = 7'h73;
          end
          // channel 4 reload set
          `DMASB_SUB_RELOAD4_SRC: begin
            slotOf = 7'h74;
          end
          `DMASB_SUB_RELOAD4_DST: begin
            slotOf = 7'h75;
          end
          `DMASB_SUB_RELOAD4_COUNT: begin
            slotOf = 7'h76;
          end
          `DMASB_SUB_RELOAD4_FRAME: begin
            slotOf = 7'h77;
          end
          // channel 5 reload set
          `DMASB_SUB_RELOAD5_SRC: begin
            slotOf = 7'h78;
          end
          `DMASB_SUB_RELOAD5_DST: begin
            slotOf = 7'h79;
          end
          `DMASB_SUB_RELOAD5_COUNT: begin
            slotOf = 7'h7a;
          end
          `DMASB_SUB_RELOAD5_FRAME: begin
            slotOf = 7'h7b;
          end
          default: begin
            slotOf = 7'h00;
          end
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire hitPrio = busSel && busAddr == `DMASB_ADDR_PRIORITY;
  wire hitPtr = busSel && busAddr == `DMASB_ADDR_POINTER;
  wire hitInc = busSel && busAddr == `DMASB_ADDR_INC_PORT;
  wire hitPlain = busSel && busAddr == `DMASB_ADDR_PLAIN_PORT;
  wire hitPort = hitInc || hitPlain;
  wire [6:0] slot = slotOf(ptr_ff);
  wire slotValid = slot[6];
  wire [5:0] slotIdx = slot[5:0];

  assign busHit = hitPrio || hitPtr || hitPort;
  assign priorityEnable = prio_ff;
  assign subbankPointer = ptr_ff;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux; writes and idle cycles return zero so the core never
  // sees stale data on a later cycle
  always @* begin
    nxt_busRdata = 16'h0000;
    if (busWrite) begin
      nxt_busRdata = 16'h0000;
    end else if (hitPrio) begin
      nxt_busRdata = prio_ff;
    end else if (hitPtr) begin
      nxt_busRdata = ptr_ff;
    end else if (hitPort && slotValid) begin
      nxt_busRdata = slot_ff[slotIdx];
    end
    // unlisted slot through a data port falls through to zero
  end

  // read data flop; one cycle after the strobe, zero otherwise
  // the flop keeps the bus output free of decode glitches
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busRdata <= 16'h0000;
    end else begin
      busRdata <= nxt_busRdata;
    end
  end

  // ----------------------------------------------------------------
  // subbank pointer
  // ----------------------------------------------------------------
  // a direct write wins over a step; the two cannot meet because they
  // sit at different addresses, but the order keeps the intent plain
  always @* begin
    nxt_ptr = ptr_ff;
    if (hitPtr && busWrite) begin
      nxt_ptr = busWdata;
    end else if (hitInc) begin
      // post-increment on read and write alike; wraps at 16 bits, so
      // stepping past the last register lands on unlisted subaddresses
      nxt_ptr = ptr_ff + 16'h0001;
    end
    // plain port falls through with the pointer held
  end

  // pointer flop; the slot decode reads it, so a step takes effect
  // from the access after the one that caused it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff <= `DMASB_RST_POINTER;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // ----------------------------------------------------------------
  // direct priority/enable register
  // ----------------------------------------------------------------
  // held in its own flop, never in the subbank slots
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prio_ff <= `DMASB_RST_REG;
    end else if (hitPrio && busWrite) begin
      prio_ff <= busWdata;
    end
  end

  // ----------------------------------------------------------------
  // subbank storage
  // ----------------------------------------------------------------
  // unmapped slots take no write; the write lands on the same edge as
  // any pointer step, so the step never moves the target mid-access
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `DMASB_SLOT_COUNT; i = i + 1) begin
        slot_ff[i] <= `DMASB_RST_REG;
      end
    end else if (hitPort && busWrite && slotValid) begin
      slot_ff[slotIdx] <= busWdata;
    end
  end

endmodule
`default_nettype wire

// ==== verification/dmasb_core_model.sv ====
/* core-side bus master model. assumes dmasb_regs timing */
`timescale 1ns/1ns
`default_nettype none
module dmasb_core_model (
  input wire logic mclk,
  output logic busSel,
  output logic busWrite,
  output logic [15:0] busAddr,
  output logic [15:0] busWdata,
  input wire logic [15:0] busRdata
);
  initial begin
    {busSel, busWrite, busAddr, busWdata} = '0;
  end
  // one access; released lines show inverted values
  task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge mclk);
    {busSel, busWrite, busAddr, busWdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    {busSel, busAddr, busWdata} <= {1'b0, ~a, ~d};
    #1 q = busRdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/dmasb_regs_checker.sv ====
/* port checker for dmasb_regs. assumes bind below */
`timescale 1ns/1ns
`default_nettype none
module dmasb_regs_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic busSel,
  input wire logic busWrite,
  input wire logic busHit,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic [15:0] priorityEnable,
  input wire logic [15:0] subbankPointer
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire rd = busSel && !busWrite;
  wire wr = busSel && busWrite;
  sequence plainWr;
    wr && busAddr == 16'h0057 && subbankPointer < 16'h0028 ##1 !busSel;
  endsequence
  hit_decode_a: assert property (busHit == (busSel && busAddr[15:2] == 14'h0015)) else $error("hit");
  inc_step_a: assert property (busSel && busAddr == 16'h0056 |=>
    subbankPointer == $past(subbankPointer) + 16'h0001) else $error("inc");
  plain_hold_a: assert property (busSel && busAddr == 16'h0057 |=> $stable(subbankPointer)) else $error("hold");
  ptr_load_a: assert property (wr && busAddr == 16'h0055 |=> subbankPointer == $past(busWdata)) else $error("ptr");
  prio_load_a: assert property (wr && busAddr == 16'h0054 |=> priorityEnable == $past(busWdata)) else $error("prio");
  idle_zero_a: assert property (!rd |=> busRdata == 16'h0000) else $error("idle");
  rsvd_zero_a: assert property (rd && busAddr[15:1] == 15'h002b && (subbankPointer[15:1] == 15'h0014
    || subbankPointer > 16'h003d) |=> busRdata == 16'h0000) else $error("rsvd");
  wr_rd_a: assert property (plainWr ##1 rd && busAddr == 16'h0057 |=>
    busRdata == $past(busWdata, 3)) else $error("wrrd");
endmodule
bind dmasb_regs dmasb_regs_checker chk_i (.mclk, .rst_b, .busSel, .busWrite, .busHit, .busAddr,
  .busWdata, .busRdata, .priorityEnable, .subbankPointer);
`default_nettype wire

// ==== verification/test_dma_subbank_register_access.sv ====
/* self-checking bench. assumes dmasb_core_model drives the bus */
`timescale 1ns/1ns
`default_nettype none
module test_dma_subbank_register_access;
  logic mclk = 0, rst_b = 0, busSel, busWrite, busHit;
  logic [15:0] busAddr, busWdata, busRdata, priorityEnable, subbankPointer, q;
  int failures = 0, tests_run = 0;
  // subaddress, expected readback of {5a, sub}
  logic [31:0] rows [13] = '{32'h0000_5a00, 32'h001d_5a1d, 32'h001e_5a1e, 32'h001f_5a1f,
    32'h0020_5a20, 32'h0023_5a23, 32'h0024_5a24, 32'h0027_5a27, 32'h0028_0000, 32'h0029_0000,
    32'h002a_5a2a, 32'h003d_5a3d, 32'h003e_0000};
  always #5 mclk = ~mclk;
  dmasb_regs uut (.mclk, .rst_b, .busSel, .busWrite, .busAddr, .busWdata, .busRdata, .busHit,
    .priorityEnable, .subbankPointer);
  dmasb_core_model m (.mclk, .busSel, .busWrite, .busAddr, .busWdata, .busRdata);
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    chk("pointer", 16'h0, subbankPointer);
    foreach (rows[i]) begin
      m.acc(1, 16'h55, rows[i][31:16], q);
      m.acc(1, 16'h57, {8'h5a, rows[i][23:16]}, q);
      m.acc(0, 16'h57, 16'h0, q);
      chk("subreg", rows[i][15:0], q);
    end
    $display("map test done");
    m.acc(1, 16'h55, 16'h1e, q);
    for (int i = 0; i < 3; i++) m.acc(1, 16'h56, 16'h1000 + i[15:0], q);
    chk("ptrinc", 16'h21, subbankPointer);
    m.acc(1, 16'h55, 16'h1e, q);
    for (int i = 0; i < 3; i++) begin
      m.acc(0, 16'h56, 16'h0, q);
      chk("burst", 16'h1000 + i[15:0], q);
    end
    m.acc(1, 16'h54, 16'h00c3, q);
    m.acc(0, 16'h54, 16'h0, q);
    chk("prio", 16'h00c3, q);
    m.acc(0, 16'h53, 16'h0, q);
    chk("unmapped", 16'h0, q);
    m.acc(1, 16'h55, 16'h24, q);
    m.acc(0, 16'h57, 16'h0, q);
    chk("plainhold", 16'h24, subbankPointer);
    chk("prioport", 16'h00c3, priorityEnable);
    $display("special test done");
    // reset in mid-run clears every register
    @(posedge mclk);
    rst_b <= 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    chk("rstprio", 16'h0, priorityEnable);
    chk("rstptr", 16'h0, subbankPointer);
    m.acc(1, 16'h55, 16'h1e, q);
    m.acc(0, 16'h57, 16'h0, q);
    chk("rstslot", 16'h0, q);
    $display("reset test done");
    report_and_stop;
  end
  // watchdog, runs about seventeen times the expected length
  initial begin
    #20000;
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
